// ### design/ecdc_pkg.sv
// Shared constants of the E1 channel digital control block.
// Assumes a 25 MHz master clock and APB register access on that clock.
package ecdc_pkg;
   localparam int NUM_CH = 4;
   localparam int CTRL_W = 11;

   // APB map: channel c at c*CH_STRIDE
   localparam logic [7:0] OFS_CH_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CH_STAT  = 8'h04;
   localparam logic [7:0] CH_STRIDE    = 8'h08;
   localparam logic [7:0] OFS_SOFT_RST = 8'h20;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // Control bits
   localparam int CB_CODE_AMI    = 0;
   localparam int CB_SINGLE_RAIL = 1;
   localparam int CB_RX_MUTE     = 2;
   localparam int CB_POL_INV     = 3;
   localparam int CB_TX_EDGE     = 4;
   localparam int CB_RX_EDGE     = 5;
   localparam int CB_ALL_ONES    = 6;
   localparam int CB_TX_OFF      = 7;
   localparam int CB_REMOTE_LOOPBACK_MODE       = 8;
   localparam int CB_DIGITAL_LOCAL_LOOPBACK_MODE       = 9;
   localparam int CB_ANALOG_LOCAL_LOOPBACK_MODE       = 10;

   // Status bits
   localparam int SB_LOS      = 0;
   localparam int SB_ALOS     = 1;
   localparam int SB_DLOS     = 2;
   localparam int SB_DRV_FAIL = 3;
   localparam int SB_SOFT_RST = 0;

   // Timing
   localparam int MCLK_PS      = 40000;
   localparam int MCLK_NS      = 40;
   localparam int BIT_PS       = 488281;
   localparam int ALOS_BITS    = 32;
   localparam int TCLK_LOSS_NS = 10000;
   localparam logic [8:0] ALOS_CYC =
      9'((ALOS_BITS * BIT_PS + MCLK_PS - 1) / MCLK_PS);
   localparam logic [8:0] TCLK_LOSS_CYC =
      9'((TCLK_LOSS_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [3:0] FB_HALF_CYC = 4'(BIT_PS / (2 * MCLK_PS));
   localparam logic [8:0] DMON_CYC = 9'd128;

   // Loss and code counts
   localparam logic [5:0] ZERO_DECL = 6'd32;
   localparam logic [5:0] RUN_MAX   = 6'd16;
   localparam logic [5:0] HDB3_RUN  = 6'd4;
   localparam logic [4:0] WIN_LAST  = 5'd31;
   localparam logic [2:0] WIN_ONES  = 3'd4;
endpackage

// ### design/ecdc_sync.sv
// Three-stage input synchroniser with edge pulses.
// Assumes asynchronous inputs; a change counts once stages two and three agree.
module ecdc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] lvl_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);
   logic [W-1:0] q1;
   logic [W-1:0] q2;
   logic [W-1:0] q3;
   logic [W-1:0] next_lvl;

   always_comb begin
      next_lvl = (q2 & q3) | (lvl_o & (q2 | q3));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q1     <= '0;
         q2     <= '0;
         q3     <= '0;
         lvl_o  <= '0;
         rise_o <= '0;
         fall_o <= '0;
      end else begin
         q1     <= d_i;
         q2     <= q1;
         q3     <= q2;
         lvl_o  <= next_lvl;
         rise_o <= next_lvl & ~lvl_o;
         fall_o <= ~next_lvl & lvl_o;
      end
   end
endmodule // ecdc_sync

// ### design/ecdc_top.sv
// Four-channel E1 line digital control: loss detection, loop-backs,
// HDB3/AMI coding, polarity and edge selection, driver monitor, APB regs.
// Assumes slicer, clock recovery and amplitude comparators outside.

module ecdc_top #(
   parameter int NCH = ecdc_pkg::NUM_CH
) (
   input  wire logic           mclk_i,
   input  wire logic           sys_rst_i,
   input  wire logic           psel_i,
   input  wire logic           penable_i,
   input  wire logic           pwrite_i,
   input  wire logic [7:0]     paddr_i,
   input  wire logic [31:0]    pwdata_i,
   output logic      [31:0]    prdata_o,
   output logic                pready_o,
   output logic                pslverr_o,
   input  wire logic [NCH-1:0] tx_clock_in_i,
   input  wire logic [NCH-1:0] tx_positive_data_i,
   input  wire logic [NCH-1:0] tx_negative_data_i,
   input  wire logic [NCH-1:0] rx_clock_in_i,
   input  wire logic [NCH-1:0] line_rx_plus_i,
   input  wire logic [NCH-1:0] line_rx_minus_i,
   input  wire logic [NCH-1:0] amp_below_declare_i,
   input  wire logic [NCH-1:0] amp_above_clear_i,
   output logic      [NCH-1:0] recovered_clock_out_o,
   output logic      [NCH-1:0] rx_positive_data_o,
   output logic      [NCH-1:0] rx_negative_or_violation_o,
   output logic      [NCH-1:0] line_tx_plus_o,
   output logic      [NCH-1:0] line_tx_minus_o,
   output logic      [NCH-1:0] line_tx_oe_o,
   output logic      [NCH-1:0] loss_of_signal_o
);
   logic [ecdc_pkg::CTRL_W-1:0] ctrl [NCH];
   logic [3:0]                  stat_v [NCH];
   logic [NCH-1:0]              drv_fail;
   logic [NCH-1:0]              dfail_set;
   logic                        soft_rst;
   logic                        irst;
   logic [1:0]                  a_idx;
   logic                        a_ch;
   logic                        a_sw;
   logic                        a_stat;
   logic                        acc_wr;
   logic [31:0]                 rdata;

   // Interface state restarts on either reset; registers only on hardware reset
   assign irst = sys_rst_i | soft_rst;

   always_comb begin
      a_idx  = paddr_i[4:3];
      a_stat = paddr_i[2];
      a_ch   = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0) && (int'(a_idx) < NCH);
      a_sw   = (paddr_i == ecdc_pkg::OFS_SOFT_RST);
      acc_wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
      rdata  = 32'h0000_0000;
      if (a_ch && !a_stat) begin
         rdata[ecdc_pkg::CTRL_W-1:0] = ctrl[a_idx];
      end else if (a_ch) begin
         rdata[3:0] = stat_v[a_idx];
      end
   end

   // No wait state: answer registered in the setup cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         pready_o  <= 1'b1;
         pslverr_o <= ~(a_ch | a_sw);
         prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= acc_wr & a_sw & pwdata_i[ecdc_pkg::SB_SOFT_RST];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            ctrl[i] <= ecdc_pkg::CTRL_RST;
         end
      end else if (acc_wr && a_ch && !a_stat) begin
         ctrl[a_idx] <= pwdata_i[ecdc_pkg::CTRL_W-1:0];
      end
   end

   // Sticky failure flag, write one to clear; a new event wins over the clear
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < NCH; i++) begin
         if (sys_rst_i) begin
            drv_fail[i] <= 1'b0;
         end else if (dfail_set[i]) begin
            drv_fail[i] <= 1'b1;
         end else if (acc_wr && a_ch && a_stat && int'(a_idx) == i
                      && pwdata_i[ecdc_pkg::SB_DRV_FAIL]) begin
            drv_fail[i] <= 1'b0;
         end
      end
   end

   genvar c;
   for (c = 0; c < NCH; c++) begin : g_ch
      logic [7:0]                  s;
      logic [7:0]                  sr;
      logic [7:0]                  sf;
      logic [ecdc_pkg::CTRL_W-1:0] cf;
      logic single, hdb3, pol, remote_loopback_mode, local_lb, txlost, allones;
      logic enc_tick, line_tick, rx_tick, txp, txn, din, emit, mk, viol;
      logic below, above, rclk, upd;
      logic [8:0] tidle;
      logic [8:0] didle;
      logic [8:0] acnt;
      logic [3:0] div;
      logic       divl;
      logic       fb_rise;
      logic [3:0] esr, efb, efv, next_esr, next_efb, next_efv;
      logic       epol, epar, next_epol, next_epar;
      logic       lp, ln, next_lp, next_ln, loe, plp, pln;
      logic [3:0] dsr, dlv, next_dsr, next_dlv;
      logic       rpol, next_rpol, stg_p, stg_n;
      logic [5:0] zcnt;
      logic [4:0] wcnt;
      logic [2:0] ones;
      logic       alos, dlos, loss_of_signal, rco, rxpo, rxno;

      ecdc_sync #(.W(8)) u_sync (
         .clk_i  (mclk_i),
         .rst_i  (sys_rst_i),
         .d_i    ({amp_above_clear_i[c], amp_below_declare_i[c],
                   line_rx_minus_i[c], line_rx_plus_i[c], rx_clock_in_i[c],
                   tx_negative_data_i[c], tx_positive_data_i[c], tx_clock_in_i[c]}),
         .lvl_o  (s),
         .rise_o (sr),
         .fall_o (sf)
      );

      always_comb begin
         cf        = ctrl[c];
         single    = cf[ecdc_pkg::CB_SINGLE_RAIL];
         hdb3      = single & ~cf[ecdc_pkg::CB_CODE_AMI];
         pol       = cf[ecdc_pkg::CB_POL_INV];
         remote_loopback_mode     = cf[ecdc_pkg::CB_REMOTE_LOOPBACK_MODE];
         local_lb  = cf[ecdc_pkg::CB_DIGITAL_LOCAL_LOOPBACK_MODE] | cf[ecdc_pkg::CB_ANALOG_LOCAL_LOOPBACK_MODE];
         txlost    = tidle > ecdc_pkg::TCLK_LOSS_CYC;
         allones   = (cf[ecdc_pkg::CB_ALL_ONES] | txlost) & ~remote_loopback_mode;
         line_tick = sr[3];
         if (remote_loopback_mode) begin
            enc_tick = line_tick;
         end else if (txlost) begin
            enc_tick = fb_rise;
         end else begin
            enc_tick = cf[ecdc_pkg::CB_TX_EDGE] ? sr[0] : sf[0];
         end
         rx_tick = local_lb ? enc_tick : line_tick;
         txp     = s[1] ^ pol;
         txn     = s[2] ^ pol;
         if (allones) begin
            din = 1'b1;
         end else begin
            din = remote_loopback_mode ? dsr[3] : txp;
         end
         rclk  = local_lb ? (txlost ? divl : s[0]) : s[3];
         upd   = cf[ecdc_pkg::CB_RX_EDGE] ? (rco & ~rclk) : (~rco & rclk);
         below = local_lb ? 1'b0 : s[6];
         above = local_lb ? 1'b1 : s[7];
      end

      // Transmit clock watchdog and master-clock bit timing fallback
      always_ff @(posedge mclk_i) begin
         if (irst) begin
            tidle <= 9'h000;
         end else if (sr[0] | sf[0]) begin
            tidle <= 9'h000;
         end else if (tidle <= ecdc_pkg::TCLK_LOSS_CYC) begin
            tidle <= tidle + 9'h001;
         end
      end

      always_ff @(posedge mclk_i) begin
         if (irst) begin
            div     <= 4'h0;
            divl    <= 1'b0;
            fb_rise <= 1'b0;
         end else if (div == ecdc_pkg::FB_HALF_CYC - 4'h1) begin
            div     <= 4'h0;
            divl    <= ~divl;
            fb_rise <= ~divl;
         end else begin
            div     <= div + 4'h1;
            fb_rise <= 1'b0;
         end
      end

      // Encoder: four-bit lookahead for substitutions
      always_comb begin
         next_esr  = {esr[2:0], din};
         next_efb  = {efb[2:0], 1'b0};
         next_efv  = {efv[2:0], 1'b0};
         emit      = esr[3] | efb[3] | efv[3];
         next_epol = emit ? (efv[3] ? epol : ~epol) : epol;
         next_epar = efv[3] ? 1'b0 : (epar ^ emit);
         if (hdb3 && next_esr == 4'h0 && next_efv == 4'h0) begin
            next_efv[0] = 1'b1;
            next_efb[3] = ~next_epar;
         end
         next_lp = emit & next_epol;
         next_ln = emit & ~next_epol;
         if (!single && !allones) begin
            next_lp = remote_loopback_mode ? s[4] : txp;
            next_ln = (remote_loopback_mode ? s[5] : txn) & ~next_lp;
         end
      end

      always_ff @(posedge mclk_i) begin
         if (irst) begin
            esr  <= 4'h0;
            efb  <= 4'h0;
            efv  <= 4'h0;
            epol <= 1'b0;
            epar <= 1'b0;
            lp   <= 1'b0;
            ln   <= 1'b0;
         end else if (enc_tick) begin
            esr  <= next_esr;
            efb  <= next_efb;
            efv  <= next_efv;
            epol <= next_epol;
            epar <= next_epar;
            lp   <= next_lp;
            ln   <= next_ln;
         end
      end

      always_ff @(posedge mclk_i) begin
         if (irst) begin
            loe <= 1'b0;
         end else begin
            loe <= ~cf[ecdc_pkg::CB_TX_OFF];
         end
      end

      // Driver monitor
      always_ff @(posedge mclk_i) begin
         if (irst) begin
            plp   <= 1'b0;
            pln   <= 1'b0;
            didle <= 9'h000;
         end else begin
            plp <= lp;
            pln <= ln;
            if ({lp, ln} != {plp, pln}) begin
               didle <= 9'h000;
            end else if (didle < ecdc_pkg::DMON_CYC) begin
               didle <= didle + 9'h001;
            end
         end
      end

      assign dfail_set[c] = ({lp, ln} == {plp, pln})
                            && (didle == ecdc_pkg::DMON_CYC - 9'h001);

      // Decoder: removes substitutions, flags violations and excess zeros
      always_comb begin
         mk        = s[4] | s[5];
         if (local_lb) begin
            mk = lp | ln;
         end
         viol      = mk & ((local_lb ? lp : s[4]) == rpol);
         next_dsr  = {dsr[2:0], mk};
         next_dlv  = {dlv[2:0], 1'b0};
         next_rpol = mk ? (local_lb ? lp : s[4]) : rpol;
         if (single && viol) begin
            if (hdb3 && dsr[1:0] == 2'b00) begin
               next_dsr[0] = 1'b0;
               next_dsr[3] = 1'b0;
            end else begin
               next_dlv[0] = 1'b1;
            end
         end
         if (hdb3 && !mk && zcnt == ecdc_pkg::HDB3_RUN - 6'd1) begin
            next_dlv[0] = 1'b1;
         end
      end

      always_ff @(posedge mclk_i) begin
         if (irst) begin
            dsr   <= 4'h0;
            dlv   <= 4'h0;
            rpol  <= 1'b0;
            stg_p <= 1'b0;
            stg_n <= 1'b0;
         end else if (rx_tick) begin
            dsr   <= next_dsr;
            dlv   <= next_dlv;
            rpol  <= next_rpol;
            stg_p <= single ? dsr[3] : (local_lb ? lp : s[4]);
            stg_n <= single ? dlv[3] : (local_lb ? ln : s[5]);
         end
      end

      // Zero-run loss detector
      always_ff @(posedge mclk_i) begin
         if (irst) begin
            zcnt <= 6'h00;
            wcnt <= 5'h00;
            ones <= 3'h0;
            dlos <= 1'b0;
         end else if (rx_tick) begin
            if (mk) begin
               zcnt <= 6'h00;
            end else if (zcnt < ecdc_pkg::ZERO_DECL) begin
               zcnt <= zcnt + 6'h01;
            end
            if (!dlos) begin
               wcnt <= 5'h00;
               ones <= 3'h0;
               if (!mk && zcnt == ecdc_pkg::ZERO_DECL - 6'd1) begin
                  dlos <= 1'b1;
               end
            end else if (!mk && zcnt >= ecdc_pkg::RUN_MAX - 6'd1) begin
               wcnt <= 5'h00;
               ones <= 3'h0;
            end else if (wcnt == ecdc_pkg::WIN_LAST) begin
               wcnt <= 5'h00;
               ones <= 3'h0;
               if (ones + {2'b00, mk} >= ecdc_pkg::WIN_ONES) begin
                  dlos <= 1'b0;
               end
            end else begin
               wcnt <= wcnt + 5'h01;
               if (mk && ones < ecdc_pkg::WIN_ONES) begin
                  ones <= ones + 3'h1;
               end
            end
         end
      end

      // Amplitude loss detector
      always_ff @(posedge mclk_i) begin
         if (irst) begin
            acnt <= 9'h000;
            alos <= 1'b0;
         end else begin
            if (!below) begin
               acnt <= 9'h000;
            end else if (acnt < ecdc_pkg::ALOS_CYC) begin
               acnt <= acnt + 9'h001;
            end
            if (below && acnt == ecdc_pkg::ALOS_CYC - 9'h001) begin
               alos <= 1'b1;
            end else if (above) begin
               alos <= 1'b0;
            end
         end
      end

      // Receive outputs
      always_ff @(posedge mclk_i) begin
         if (irst) begin
            loss_of_signal  <= 1'b0;
            rco  <= 1'b0;
            rxpo <= 1'b0;
            rxno <= 1'b0;
         end else begin
            loss_of_signal <= alos & dlos;
            rco <= rclk;
            if (cf[ecdc_pkg::CB_RX_MUTE] && loss_of_signal) begin
               rxpo <= 1'b0;
               rxno <= 1'b0;
            end else if (upd) begin
               rxpo <= stg_p ^ pol;
               rxno <= stg_n ^ pol;
            end
         end
      end

      assign stat_v[c]                    = {drv_fail[c], dlos, alos, loss_of_signal};
      assign recovered_clock_out_o[c]     = rco;
      assign rx_positive_data_o[c]        = rxpo;
      assign rx_negative_or_violation_o[c] = rxno;
      assign line_tx_plus_o[c]            = lp;
      assign line_tx_minus_o[c]           = ln;
      assign line_tx_oe_o[c]              = loe;
      assign loss_of_signal_o[c]          = loss_of_signal;
   end
endmodule // ecdc_top

// ### tb/ecdc_monitor.sv
// Assertions on the top ports of the E1 channel control block.
// Assumes control state changes only through completed APB writes.
module ecdc_monitor #(
   parameter int NCH = ecdc_pkg::NUM_CH
) (
   input wire logic           mclk_i,
   input wire logic           sys_rst_i,
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic           pwrite_i,
   input wire logic [7:0]     paddr_i,
   input wire logic [31:0]    pwdata_i,
   input wire logic [31:0]    prdata_o,
   input wire logic           pready_o,
   input wire logic           pslverr_o,
   input wire logic [NCH-1:0] amp_above_clear_i,
   input wire logic [NCH-1:0] rx_positive_data_o,
   input wire logic [NCH-1:0] rx_negative_or_violation_o,
   input wire logic [NCH-1:0] line_tx_plus_o,
   input wire logic [NCH-1:0] line_tx_minus_o,
   input wire logic [NCH-1:0] line_tx_oe_o,
   input wire logic [NCH-1:0] loss_of_signal_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] ctl [NCH];
   logic        ones0;

   // Shadow of the control words, taken at the completing edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         for (int c = 0; c < NCH; c++) ctl[c] <= '0;
      end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i[2:0] == 3'h0
                   && paddr_i < 8'h20) begin
         ctl[paddr_i[4:3]] <= pwdata_i[10:0];
      end
   end
   assign ones0 = ctl[0][6] && !ctl[0][7] && !ctl[0][8];

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_apb_err: assert property (psel_i && !penable_i && paddr_i > 8'h20 |=> pslverr_o)
      else $error("unmapped access not refused");
   a_reset_quiet: assert property (disable iff (1'h0) sys_rst_i |=>
      !pready_o && loss_of_signal_o == '0 && line_tx_oe_o == '0)
      else $error("outputs active after reset");
   a_los_clear: assert property (amp_above_clear_i[3] [*8] |-> !loss_of_signal_o[3])
      else $error("loss held with amplitude restored");
   a_mute_low: assert property ((ctl[3][2] && loss_of_signal_o[3]) [*3] |->
      !rx_positive_data_o[3] && !rx_negative_or_violation_o[3])
      else $error("receive data not muted");
   a_rails_excl: assert property (!(|(line_tx_plus_o & line_tx_minus_o)))
      else $error("both line rails marked");
   a_ones_marks: assert property (ones0 [*8] |-> ##[0:60]
      (line_tx_plus_o[0] || line_tx_minus_o[0]))
      else $error("no marks while sending all ones");
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      a_transmitter_shutdown_hiz: assert property (ctl[c][7] [*3] |-> !line_tx_oe_o[c])
         else $error("line driven while shut down");
   end
endmodule // ecdc_monitor

bind ecdc_top ecdc_monitor #(.NCH(NCH)) u_mon (
   .mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .prdata_o, .pready_o, .pslverr_o, .amp_above_clear_i, .rx_positive_data_o,
   .rx_negative_or_violation_o, .line_tx_plus_o, .line_tx_minus_o,
   .line_tx_oe_o, .loss_of_signal_o
);

// ### tb/ecdc_framer_model.sv
// Framer model: transmit clock and NRZ data for every channel.
// Assumes the bench starts and stops the clock through run_i.
module ecdc_framer_model #(
   parameter int NCH = 4
) (
   input  wire logic           run_i,
   input  wire logic           pat_i,
   output logic      [NCH-1:0] tx_clk_o,
   output logic      [NCH-1:0] tx_pos_o,
   output logic      [NCH-1:0] tx_neg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph = 1'h0;

   initial begin
      tx_clk_o = '1;
      tx_pos_o = '0;
      tx_neg_o = '0;
      #7;
      forever begin
         #160;
         // A stopped clock rests high
         tx_clk_o = run_i ? ~tx_clk_o : '1;
         if (run_i && tx_clk_o[0]) begin
            ph = ~ph;
            tx_pos_o = pat_i ? {NCH{ph}} : '0;
         end
      end
   end
endmodule // ecdc_framer_model

// ### tb/tb.sv
// Self-checking bench for the E1 channel control block.
// Assumes the framer model and the bound checker are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = ecdc_pkg::NUM_CH;
   logic           mclk_i = 1'h0;
   logic           sys_rst_i = 1'h1;
   logic           psel_i = 1'h0;
   logic           penable_i = 1'h0;
   logic           pwrite_i = 1'h0;
   logic [7:0]     paddr_i = 8'h00;
   logic [31:0]    pwdata_i = 32'h0;
   logic [31:0]    prdata_o, rd;
   logic           pready_o, pslverr_o, err;
   logic [NCH-1:0] tx_clock_in_i, tx_positive_data_i, tx_negative_data_i;
   logic [NCH-1:0] rx_clock_in_i = '0;
   logic [NCH-1:0] line_rx_plus_i = '0;
   logic [NCH-1:0] line_rx_minus_i = '0;
   logic [NCH-1:0] amp_below_declare_i = '0;
   logic [NCH-1:0] amp_above_clear_i = '1;
   logic [NCH-1:0] recovered_clock_out_o, rx_positive_data_o, rx_negative_or_violation_o;
   logic [NCH-1:0] line_tx_plus_o, line_tx_minus_o, line_tx_oe_o, loss_of_signal_o;
   logic           run = 1'h1;
   logic           pat = 1'h0;
   logic [31:0]    cfg [NCH] = '{32'h43, 32'h8, 32'h0, 32'hc};
   int             n_fail = 0;
   int             checks = 0;
   int             np, nm;
   logic           rc;

   always #20 mclk_i = ~mclk_i;
   initial begin
      #13;
      forever #160 rx_clock_in_i = ~rx_clock_in_i;
   end

   ecdc_framer_model #(.NCH(NCH)) u_framer (
      .run_i    (run),
      .pat_i    (pat),
      .tx_clk_o (tx_clock_in_i),
      .tx_pos_o (tx_positive_data_i),
      .tx_neg_o (tx_negative_data_i)
   );
   ecdc_top #(.NCH(NCH)) u_dut (
      .mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .tx_clock_in_i, .tx_positive_data_i,
      .tx_negative_data_i, .rx_clock_in_i, .line_rx_plus_i, .line_rx_minus_i,
      .amp_below_declare_i, .amp_above_clear_i, .recovered_clock_out_o,
      .rx_positive_data_o, .rx_negative_or_violation_o, .line_tx_plus_o,
      .line_tx_minus_o, .line_tx_oe_o, .loss_of_signal_o
   );

   function automatic logic [7:0] ca(input int c, input logic [7:0] o);
      return o + 8'(c) * ecdc_pkg::CH_STRIDE;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_i <= 1'h1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'h1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      chk("pready", 1, n < 20);
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask

   task automatic marks(input int span);
      np = 0;
      nm = 0;
      repeat (span) begin
         @(posedge mclk_i);
         np += int'(line_tx_plus_o[0]);
         nm += int'(line_tx_minus_o[0]);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      n_fail++;
      $display("watchdog expired");
      end_of_test();
   end

   initial begin
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'h0;
      for (int c = 0; c < NCH; c++) begin
         apb(0, ca(c, ecdc_pkg::OFS_CH_CTRL), 0);
         chk("ctrl reset", 0, rd);
         apb(1, ca(c, ecdc_pkg::OFS_CH_CTRL), cfg[c]);
      end
      apb(1, ecdc_pkg::OFS_SOFT_RST, 32'h1);
      for (int c = 0; c < NCH; c++) begin
         apb(0, ca(c, ecdc_pkg::OFS_CH_CTRL), 0);
         chk("ctrl kept", cfg[c], rd);
      end
      apb(0, 8'h30, 0);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("test registers done");
      repeat (100) @(posedge mclk_i);
      chk("tx inverted", 1, line_tx_plus_o[1]);
      chk("tx plain", 0, line_tx_plus_o[2]);
      chk("rx inverted", 1, rx_positive_data_o[1]);
      marks(300);
      chk("ones marks", 1, np > 100 && nm > 100);
      run <= 1'h0;
      repeat (300) @(posedge mclk_i);
      marks(300);
      chk("fallback marks", 1, np > 100 && nm > 100);
      run <= 1'h1;
      $display("test all ones done");
      apb(0, ca(2, ecdc_pkg::OFS_CH_STAT), 0);
      chk("quiet driver", 32'hc, rd);
      pat <= 1'h1;
      repeat (50) @(posedge mclk_i);
      apb(1, ca(2, ecdc_pkg::OFS_CH_STAT), 32'h8);
      repeat (200) @(posedge mclk_i);
      apb(0, ca(2, ecdc_pkg::OFS_CH_STAT), 0);
      chk("driver cleared", 0, rd & 32'h8);
      $display("test driver monitor done");
      apb(0, ca(3, ecdc_pkg::OFS_CH_STAT), 0);
      chk("zero run only", 32'h4, rd & 32'h7);
      amp_below_declare_i[3] <= 1'h1;
      amp_above_clear_i[3] <= 1'h0;
      repeat (300) @(posedge mclk_i);
      chk("early loss", 0, loss_of_signal_o[3]);
      repeat (150) @(posedge mclk_i);
      chk("loss", 1, loss_of_signal_o[3]);
      chk("muted", 0, {rx_positive_data_o[3], rx_negative_or_violation_o[3]});
      apb(0, ca(3, ecdc_pkg::OFS_CH_STAT), 0);
      chk("loss status", 32'h7, rd & 32'h7);
      amp_below_declare_i[3] <= 1'h0;
      repeat (50) @(posedge mclk_i);
      chk("hysteresis", 1, loss_of_signal_o[3]);
      amp_above_clear_i[3] <= 1'h1;
      repeat (20) @(posedge mclk_i);
      chk("loss cleared", 0, loss_of_signal_o[3]);
      repeat (40) @(posedge mclk_i);
      chk("unmuted", 1, rx_positive_data_o[3]);
      $display("test loss of signal done");
      pat <= 1'h0;
      line_rx_plus_i[2] <= 1'h1;
      apb(1, ca(0, ecdc_pkg::OFS_CH_CTRL), 32'h2);
      apb(1, ca(1, ecdc_pkg::OFS_CH_CTRL), 32'h208);
      apb(1, ca(2, ecdc_pkg::OFS_CH_CTRL), 32'h100);
      apb(1, ca(3, ecdc_pkg::OFS_CH_CTRL), 32'h408);
      repeat (60) @(posedge mclk_i);
      chk("digital loop", 0, rx_positive_data_o[1]);
      chk("remote loop", 1, line_tx_plus_o[2]);
      chk("loop rx out", 1, rx_positive_data_o[2]);
      chk("analog loop", 0, rx_positive_data_o[3]);
      rc = recovered_clock_out_o[0];
      repeat (4) @(posedge mclk_i);
      chk("rx clock", {~rc}, recovered_clock_out_o[0]);
      marks(300);
      chk("hdb3 marks", 1, np > 50 && nm > 50);
      apb(0, ca(2, ecdc_pkg::OFS_CH_STAT), 0);
      chk("zero run cleared", 0, rd & 32'h4);
      $display("test loop-back and coding done");
      apb(1, ca(0, ecdc_pkg::OFS_CH_CTRL), 32'hc3);
      repeat (5) @(posedge mclk_i);
      chk("shut down", 0, line_tx_oe_o[0]);
      chk("other driven", 1, line_tx_oe_o[1]);
      $display("test shutdown done");
      end_of_test();
   end
endmodule // tb
